// ---- rtl/debug_enclave_read.sv ----
// debug enclave read leaf: wishbone register front end, page map port, irq
// assumes the page map answers on the same clock, holding mapAck for one
// cycle while mapReq is high; software issues one read at a time
`timescale 1ns/1ps
module debug_enclave_read import debug_enclave_read_pkg::*; (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                wbCyc,
	input  wire logic                wbStb,
	input  wire logic                wbWe,
	input  wire logic [WB_ADR_W-1:0] wbAdr,
	input  wire logic [3:0]          wbSel,
	input  wire logic [31:0]         wbDatW,
	output logic      [31:0]         wbDatR,
	output logic                     wbAck,
	output logic                     irq,
	output logic                     mapReq,
	output logic      [63:0]         mapAddr,
	input  wire logic                mapAck,
	input  wire map_resp_s           mapResp
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOOKUP
	} fsm_e;

	typedef struct packed {
		fsm_e            fsm;
		logic [7:0]      leaf;
		logic [63:0]     addr;
		mode_s           mode;
		logic [63:0]     result;
		logic [31:0]     retCode;
		flags_s          flags;
		verdict_e        lastFault;
		logic            lastLong;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqMask;
		logic [15:0]     count;
		logic            ack;
		logic [31:0]     rdata;
		logic            irq;
		logic            mapReq;
	} state_s;

	state_s q;
	state_s d;

	logic        longMode;
	verdict_e    preVerdict;
	verdict_e    postVerdict;
	logic [63:0] readData;

	// the evaluator sees the latched operands, so the answer is stable
	read_check_eval u_eval (
		.addr        (q.addr),
		.mode        (q.mode),
		.resp        (mapResp),
		.longMode    (longMode),
		.preVerdict  (preVerdict),
		.postVerdict (postVerdict),
		.readData    (readData)
	);

	// byte-lane merge of a write into a 32-bit register
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	logic             wbHit;
	logic             wbWr;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] w1c;
	logic             start;

	always_comb begin
		d      = q;
		d.ack  = 1'b0;
		wbHit  = wbCyc & wbStb & ~q.ack;
		wbWr   = wbHit & wbWe;
		events = '0;
		w1c    = '0;
		start  = 1'b0;

		// register reads, answered one cycle after the request
		if (wbHit) begin
			d.ack = 1'b1;
			case (wbAdr)
				OFS_CMD: begin
					d.rdata = {24'h0, q.leaf};
				end
				OFS_ADDR_LO: begin
					d.rdata = q.addr[31:0];
				end
				OFS_ADDR_HI: begin
					d.rdata = q.addr[63:32];
				end
				OFS_MODE: begin
					d.rdata = {28'h0, q.mode};
				end
				OFS_RESULT_LO: begin
					d.rdata = q.result[31:0];
				end
				OFS_RESULT_HI: begin
					d.rdata = q.result[63:32];
				end
				OFS_RETCODE: begin
					d.rdata = q.retCode;
				end
				OFS_FLAGS: begin
					d.rdata = {26'h0, q.flags};
				end
				OFS_STATUS: begin
					d.rdata = {28'h0, q.lastLong, q.lastFault, q.fsm == ST_LOOKUP};
				end
				OFS_IRQ_STAT: begin
					d.rdata = {29'h0, q.irqStat};
				end
				OFS_IRQ_MASK: begin
					d.rdata = {29'h0, q.irqMask};
				end
				OFS_COUNT: begin
					d.rdata = {16'h0, q.count};
				end
				default: begin
					d.rdata = 32'h0;
				end
			endcase
		end

		// register writes; operands are frozen while a lookup is out
		if (wbWr) begin
			case (wbAdr)
				OFS_CMD: begin
					if (q.fsm == ST_IDLE && wbSel[0]) begin
						d.leaf = wbDatW[7:0];
						// only the debug read leaf starts work
						start = (wbDatW[7:0] == LEAF_DEBUG_READ);
					end
				end
				OFS_ADDR_LO: begin
					if (q.fsm == ST_IDLE) begin
						d.addr[31:0] = merge(q.addr[31:0], wbDatW, wbSel);
					end
				end
				OFS_ADDR_HI: begin
					if (q.fsm == ST_IDLE) begin
						d.addr[63:32] = merge(q.addr[63:32], wbDatW, wbSel);
					end
				end
				OFS_MODE: begin
					if (q.fsm == ST_IDLE && wbSel[0]) begin
						d.mode = mode_s'(wbDatW[3:0]);
					end
				end
				OFS_RESULT_LO: begin
					d.result[31:0] = merge(q.result[31:0], wbDatW, wbSel);
				end
				OFS_RESULT_HI: begin
					d.result[63:32] = merge(q.result[63:32], wbDatW, wbSel);
				end
				OFS_RETCODE: begin
					d.retCode = merge(q.retCode, wbDatW, wbSel);
				end
				OFS_FLAGS: begin
					if (wbSel[0]) begin
						d.flags = flags_s'(wbDatW[5:0]);
					end
				end
				OFS_IRQ_STAT: begin
					if (wbSel[0]) begin
						w1c = wbDatW[IRQ_W-1:0];
					end
				end
				OFS_IRQ_MASK: begin
					if (wbSel[0]) begin
						d.irqMask = wbDatW[IRQ_W-1:0];
					end
				end
				default: begin
					// unmapped offsets take the write and drop it
				end
			endcase
		end

		// leaf sequencing
		case (q.fsm)
			ST_IDLE: begin
				if (start) begin
					d.lastLong = longMode;
					if (preVerdict != VERDICT_OK) begin
						// fault before the map is touched; results stay put
						d.lastFault      = preVerdict;
						events[IRQ_PROT] = 1'b1;
					end else begin
						d.fsm    = ST_LOOKUP;
						d.mapReq = 1'b1;
					end
				end
			end
			ST_LOOKUP: begin
				if (mapAck) begin
					d.fsm       = ST_IDLE;
					d.mapReq    = 1'b0;
					d.lastFault = VERDICT_OK;
					case (postVerdict)
						VERDICT_OK: begin
							// completion wins over a software write in the same cycle, except result[63:32] outside long mode, which keeps the write
							if (longMode) begin
								d.result = readData;
							end else begin
								d.result[31:0] = readData[31:0];
							end
							d.retCode    = 32'h0;
							d.flags.zero = 1'b0;
							d.flags.carry    = 1'b0;
							d.flags.parity   = 1'b0;
							d.flags.auxCarry = 1'b0;
							d.flags.overflow = 1'b0;
							d.flags.sign     = 1'b0;
							d.count          = q.count + 16'h1;
							events[IRQ_DONE] = 1'b1;
						end
						VERDICT_NODBG: begin
							// data path skipped, result left as it was
							d.retCode    = PAGE_NOT_DEBUGGABLE_CODE;
							d.flags.zero = 1'b1;
							d.flags.carry    = 1'b0;
							d.flags.parity   = 1'b0;
							d.flags.auxCarry = 1'b0;
							d.flags.overflow = 1'b0;
							d.flags.sign     = 1'b0;
							d.count          = q.count + 16'h1;
							events[IRQ_DONE] = 1'b1;
						end
						VERDICT_PROT: begin
							d.lastFault      = VERDICT_PROT;
							events[IRQ_PROT] = 1'b1;
						end
						default: begin
							d.lastFault      = VERDICT_PAGE;
							events[IRQ_PAGE] = 1'b1;
						end
					endcase
				end
			end
			default: begin
				d.fsm    = ST_IDLE;
				d.mapReq = 1'b0;
			end
		endcase

		// an event in the clearing cycle survives: set beats clear
		d.irqStat = (q.irqStat & ~w1c) | events;
		d.irq     = |(d.irqStat & d.irqMask);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q.fsm       <= ST_IDLE;
			q.leaf      <= 8'h00;
			q.addr      <= 64'h0;
			q.mode      <= '0;
			q.result    <= RESULT_RST;
			q.retCode   <= RETCODE_RST;
			q.flags     <= '0;
			q.lastFault <= VERDICT_OK;
			q.lastLong  <= 1'b0;
			q.irqStat   <= '0;
			q.irqMask   <= IRQ_MASK_RST;
			q.count     <= 16'h0;
			q.ack       <= 1'b0;
			q.rdata     <= 32'h0;
			q.irq       <= 1'b0;
			q.mapReq    <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// every output straight from the state register
	assign wbDatR  = q.rdata;
	assign wbAck   = q.ack;
	assign irq     = q.irq;
	assign mapReq  = q.mapReq;
	assign mapAddr = q.addr;

endmodule : debug_enclave_read

// ---- inc/debug_enclave_read_pkg.sv ----
// package for the debug enclave read checker: register map, fields, carriers
// assumes a 25 MHz core clock and a page map responder on the same clock
// Notes on behaviour
// - long mode needs long-active and code-long bits
// - eight bytes in long mode, else four
// - misaligned target for active width gives protection fault
// - target outside protected page cache: page fault
// - concurrent map-entry modifier gives protection fault
// - invalid map entry gives page fault
// - unsupported page type gives page fault
// - pending/modified: zero flag, error code, no data
// - thread-control offset at or past limit: protection fault
// - regular/thread-control page needs owner debug attribute
// - other pages return collapsed ones or zero
// - success clears return code and zero flag
// - non-faulting end clears carry, parity, aux, overflow, sign
// - map permission bits are never checked
// - outside long mode, segment faults are protection faults
// - long mode non-canonical target is protection fault
package debug_enclave_read_pkg;

	localparam int          CLK_MHZ        = 25;
	localparam int          WB_ADR_W       = 8;

	// register byte offsets
	localparam logic [7:0]  OFS_CMD        = 8'h00;
	localparam logic [7:0]  OFS_ADDR_LO    = 8'h04;
	localparam logic [7:0]  OFS_ADDR_HI    = 8'h08;
	localparam logic [7:0]  OFS_MODE       = 8'h0c;
	localparam logic [7:0]  OFS_RESULT_LO  = 8'h10;
	localparam logic [7:0]  OFS_RESULT_HI  = 8'h14;
	localparam logic [7:0]  OFS_RETCODE    = 8'h18;
	localparam logic [7:0]  OFS_FLAGS      = 8'h1c;
	localparam logic [7:0]  OFS_STATUS     = 8'h20;
	localparam logic [7:0]  OFS_IRQ_STAT   = 8'h24;
	localparam logic [7:0]  OFS_IRQ_MASK   = 8'h28;
	localparam logic [7:0]  OFS_COUNT      = 8'h2c;

	localparam logic [7:0]  LEAF_DEBUG_READ = 8'h04;

	// page types as the map reports them
	localparam logic [2:0]  PT_REGULAR     = 3'h1;
	localparam logic [2:0]  PT_THREAD_CTRL = 3'h2;
	localparam logic [2:0]  PT_VERSION_ARR = 3'h3;
	localparam logic [2:0]  PT_SHADOW_1ST  = 3'h5;
	localparam logic [2:0]  PT_SHADOW_REST = 3'h6;

	localparam logic [11:0] THREAD_CTRL_SIZE_LIMIT   = 12'h100;
	localparam logic [31:0] PAGE_NOT_DEBUGGABLE_CODE = 32'h0000001d;
	localparam logic [63:0] SLOT_LOW_MASK            = 64'h0000000000000007;
	localparam int          CANON_MSB                = 47;

	// irq status / mask bit positions
	localparam int          IRQ_DONE       = 0;
	localparam int          IRQ_PROT       = 1;
	localparam int          IRQ_PAGE       = 2;
	localparam int          IRQ_W          = 3;

	// reset values
	localparam logic [63:0] RESULT_RST     = 64'h0000000000000000;
	localparam logic [31:0] RETCODE_RST    = 32'h00000000;
	localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

	typedef enum logic [1:0] {
		VERDICT_OK,
		VERDICT_PROT,
		VERDICT_PAGE,
		VERDICT_NODBG
	} verdict_e;

	// pipeline mode bits, MODE register bits 3..0
	typedef struct packed {
		logic segViolation;
		logic segUnusable;
		logic codeLong;
		logic longModeActive;
	} mode_s;

	// result flags, FLAGS register bits 5..0
	typedef struct packed {
		logic sign;
		logic overflow;
		logic auxCarry;
		logic parity;
		logic carry;
		logic zero;
	} flags_s;

	// page map answer, valid while mapAck is high
	typedef struct packed {
		logic        inCache;
		logic        conflict;
		logic        valid;
		logic [2:0]  pageType;
		logic        pending;
		logic        modified;
		logic        ownerDebug;
		logic [63:0] data;
	} map_resp_s;

endpackage : debug_enclave_read_pkg

// ---- rtl/read_check_eval.sv ----
// ordered check evaluation and read data shaping for the debug read
// assumes its inputs stand steady from one clock domain; purely combinational
`timescale 1ns/1ps
module read_check_eval import debug_enclave_read_pkg::*; (
	input  wire logic [63:0] addr,
	input  wire mode_s       mode,
	input  wire map_resp_s   resp,
	output logic             longMode,
	output verdict_e         preVerdict,
	output verdict_e         postVerdict,
	output logic [63:0]      readData
);

	logic        canonical;
	logic        misaligned;
	logic        isRegOrTcs;
	logic        typeOk;
	logic [63:0] slot;

	always_comb begin
		longMode   = mode.longModeActive & mode.codeLong;
		canonical  = (&addr[63:CANON_MSB]) | ~(|addr[63:CANON_MSB]);
		misaligned = longMode ? (|addr[2:0]) : (|addr[1:0]);
		// first failing check wins; order is fixed
		if (longMode && !canonical) begin
			preVerdict = VERDICT_PROT;
		end else if (!longMode && (mode.segUnusable || mode.segViolation)) begin
			preVerdict = VERDICT_PROT;
		end else if (misaligned) begin
			preVerdict = VERDICT_PROT;
		end else begin
			preVerdict = VERDICT_OK;
		end

		isRegOrTcs = (resp.pageType == PT_REGULAR) || (resp.pageType == PT_THREAD_CTRL);
		// permission bits are not even part of the answer
		typeOk = isRegOrTcs || (resp.pageType == PT_VERSION_ARR)
			|| (resp.pageType == PT_SHADOW_1ST)
			|| (resp.pageType == PT_SHADOW_REST);
		if (!resp.inCache) begin
			postVerdict = VERDICT_PAGE;
		end else if (resp.conflict) begin
			postVerdict = VERDICT_PROT;
		end else if (!resp.valid) begin
			postVerdict = VERDICT_PAGE;
		end else if (!typeOk) begin
			postVerdict = VERDICT_PAGE;
		end else if (resp.pending || resp.modified) begin
			postVerdict = VERDICT_NODBG;
		end else if (resp.pageType == PT_THREAD_CTRL
			&& addr[11:0] >= THREAD_CTRL_SIZE_LIMIT) begin
			postVerdict = VERDICT_PROT;
		end else if (isRegOrTcs && !resp.ownerDebug) begin
			postVerdict = VERDICT_PROT;
		end else begin
			postVerdict = VERDICT_OK;
		end

		slot = resp.data & ~SLOT_LOW_MASK;
		if (isRegOrTcs) begin
			readData = resp.data;
		end else if (slot != 64'h0) begin
			readData = longMode ? {64{1'b1}} : {32'h0, {32{1'b1}}};
		end else begin
			readData = 64'h0;
		end
	end

endmodule : read_check_eval

// ---- sim/debug_enclave_read_properties.sv ----
// port-level checker for the debug enclave read block
// assumes one clock domain and single wishbone cycles from the master
`timescale 1ns/1ps
module debug_enclave_read_properties import debug_enclave_read_pkg::*; (
	input wire logic                clk,
	input wire logic                arst_n,
	input wire logic                wbCyc,
	input wire logic                wbStb,
	input wire logic                wbWe,
	input wire logic [WB_ADR_W-1:0] wbAdr,
	input wire logic [3:0]          wbSel,
	input wire logic [31:0]         wbDatW,
	input wire logic [31:0]         wbDatR,
	input wire logic                wbAck,
	input wire logic                irq,
	input wire logic                mapReq,
	input wire logic [63:0]         mapAddr,
	input wire logic                mapAck,
	input wire map_resp_s           mapResp
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	logic [63:0] addr_q;
	logic [3:0]  mode_q;
	logic        take, start, lm, alignBad, canonBad, segBad;
	assign take     = wbCyc && wbStb && !wbAck && wbWe;
	assign start    = take && wbAdr == OFS_CMD && wbSel[0] && !mapReq
		&& wbDatW[7:0] == LEAF_DEBUG_READ;
	assign lm       = mode_q[0] && mode_q[1];
	assign alignBad = lm ? addr_q[2:0] != 3'h0 : addr_q[1:0] != 2'h0;
	assign canonBad = lm && addr_q[63:47] != {17{addr_q[47]}};
	assign segBad   = !lm && (mode_q[2] || mode_q[3]);
	// mirrors only what the bench writes while idle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_q <= '0;
			mode_q <= '0;
		end else if (take && !mapReq) begin
			case (wbAdr)
				OFS_ADDR_LO: addr_q[31:0]  <= wbDatW;
				OFS_ADDR_HI: addr_q[63:32] <= wbDatW;
				OFS_MODE:    mode_q        <= wbDatW[3:0];
				default:     ;
			endcase
		end
	end
	a_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("ack late");
	a_ack_pulse: assert property (wbAck |=> !wbAck)
		else $error("ack too long");
	a_align_fault: assert property (start && alignBad |=> !mapReq [*3])
		else $error("misaligned read reached map");
	a_canon_fault: assert property (start && canonBad |=> !mapReq [*3])
		else $error("non-canonical read reached map");
	a_seg_fault: assert property (start && segBad |=> !mapReq [*3])
		else $error("segment fault read reached map");
	a_map_issue: assert property (start && !alignBad && !canonBad && !segBad
		|=> mapReq && mapAddr == addr_q)
		else $error("map lookup missing");
	a_req_holds: assert property (mapReq && !mapAck |=> mapReq && $stable(mapAddr))
		else $error("map request dropped");
	a_req_drops: assert property (mapReq && mapAck |=> !mapReq)
		else $error("map request kept");
	a_irq_cause: assert property ($rose(irq) |-> $past(mapReq && mapAck)
		|| $past(mapReq && mapAck, 2) || $past(take) || $past(take, 2))
		else $error("irq without cause");
endmodule : debug_enclave_read_properties

bind debug_enclave_read debug_enclave_read_properties debug_enclave_read_properties_inst (.*);

// ---- sim/page_map_model.sv ----
// behavioural page map responder for the debug read block
// assumes the block holds mapReq until it sees mapAck
`timescale 1ns/1ps
module page_map_model import debug_enclave_read_pkg::*; (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       mapReq,
	input  wire map_resp_s  answer,
	input  wire logic [3:0] dly,
	output logic            mapAck,
	output map_resp_s       mapResp
);
	logic [3:0] wait_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_q  <= 4'h0;
			mapAck  <= 1'b0;
			mapResp <= '0;
		end else begin
			mapAck  <= 1'b0;
			// stale answer must not look valid, so it toggles
			mapResp <= ~mapResp;
			wait_q  <= 4'h0;
			if (mapReq && !mapAck) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q >= dly) begin
					mapAck  <= 1'b1;
					mapResp <= answer;
				end
			end
		end
	end
endmodule : page_map_model

// ---- sim/debug_enclave_read_bench.sv ----
// self-checking bench for the debug enclave read block
// assumes page_map_model on the map port; wishbone single cycles only
`timescale 1ns/1ps
module debug_enclave_read_bench import debug_enclave_read_pkg::*;;
	localparam logic [63:0] PRE = 64'ha5a5a5a55a5a5a5a;
	localparam logic [63:0] A   = 64'h0000000012345000;
	localparam logic [63:0] D   = 64'h1122334455667788;
	logic        clk, arst_n, wbCyc, wbStb, wbWe, wbAck, irq, mapReq, mapAck;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel, dly;
	logic [2:0]  msk;
	logic [31:0] wbDatW, wbDatR;
	logic [63:0] mapAddr;
	map_resp_s   mapResp, answer;
	int          errors, checkCount, cycles;
	logic [15:0] doneCount;
	debug_enclave_read debug_enclave_read_inst (.*);
	page_map_model page_map_model_inst (.*);
	always #20 clk = ~clk;
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : endOfTest
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			endOfTest();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= w;
		wbAdr  <= a;
		wbDatW <= d;
		do
			@(posedge clk);
		while (wbAck !== 1'b1);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	// f holds inCache, conflict, valid, type[2:0], pending, modified, ownerDebug
	task automatic run(input logic [63:0] a, input logic [3:0] m, input logic [8:0] f,
		input logic [63:0] dat, input logic [2:0] st, input logic [63:0] res,
		input logic [5:0] fl);
		logic [31:0] q;
		logic [31:0] ret;
		int          n;
		logic [1:0]  vc;
		ret = fl[0] ? PAGE_NOT_DEBUGGABLE_CODE : 32'h0;
		vc  = st[1] ? 2'h1 : (st[2] ? 2'h2 : 2'h0);
		if (st != 3'h1) begin
			res = PRE;
			fl  = 6'h3e;
			ret = 32'h77;
		end
		wr(OFS_RESULT_LO, PRE[31:0]);
		wr(OFS_RESULT_HI, PRE[63:32]);
		wr(OFS_RETCODE, 32'h77);
		wr(OFS_FLAGS, 32'h3e);
		wr(OFS_ADDR_LO, a[31:0]);
		wr(OFS_ADDR_HI, a[63:32]);
		wr(OFS_MODE, {28'h0, m});
		answer <= map_resp_s'({f, dat});
		wr(OFS_CMD, {24'h0, LEAF_DEBUG_READ});
		n = 0;
		q = 32'h1;
		while (q[0] !== 1'b0 && n < 40) begin
			xfer(1'b0, OFS_STATUS, 32'h0, q);
			n++;
		end
		// busy still set after the poll limit counts as a mismatch
		check("status", q, {28'h0, m[1] & m[0], vc, 1'b0});
		doneCount = doneCount + {15'h0, st == 3'h1};
		xfer(1'b0, OFS_IRQ_STAT, 32'h0, q);
		check("irq stat", q, 32'(st));
		check("irq", 32'(irq), 32'(|(st & msk)));
		xfer(1'b0, OFS_RESULT_LO, 32'h0, q);
		check("result lo", q, res[31:0]);
		xfer(1'b0, OFS_RESULT_HI, 32'h0, q);
		check("result hi", q, res[63:32]);
		xfer(1'b0, OFS_RETCODE, 32'h0, q);
		check("retcode", q, ret);
		xfer(1'b0, OFS_FLAGS, 32'h0, q);
		check("flags", q, 32'(fl));
		xfer(1'b0, OFS_COUNT, 32'h0, q);
		check("count", q, {16'h0, doneCount});
		wr(OFS_IRQ_STAT, 32'h7);
		@(posedge clk);
		check("irq clear", 32'(irq), 32'h0);
	endtask : run
	task automatic testReset();
		logic [31:0] q;
		logic [7:0]  regs [9] = '{OFS_RESULT_LO, OFS_RESULT_HI, OFS_RETCODE, OFS_FLAGS,
			OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_STATUS, OFS_COUNT, 8'h40};
		wr(8'h40, 32'hffffffff);
		// any other leaf is stored but must start nothing
		wr(OFS_CMD, 32'h5);
		foreach (regs[i]) begin
			xfer(1'b0, regs[i], 32'h0, q);
			check("reset value", q, 32'h0);
		end
		xfer(1'b0, OFS_CMD, 32'h0, q);
		check("other leaf", q, 32'h5);
		check("no lookup", 32'(mapReq), 32'h0);
		$display("reset test done");
	endtask : testReset
	task automatic testOk();
		msk = 3'h1;
		wr(OFS_IRQ_MASK, 32'h1);
		dly <= 4'h3;
		run(A, 4'h3, 9'h149, D, 3'h1, D, 6'h0);
		run(A + 64'h4, 4'h1, 9'h149, D, 3'h1, {PRE[63:32], D[31:0]}, 6'h0);
		run(A + 64'h4, 4'h2, 9'h149, D, 3'h1, {PRE[63:32], D[31:0]}, 6'h0);
		run(64'hffff800000000008, 4'hf, 9'h149, D, 3'h1, D, 6'h0);
		run(A + 64'hf8, 4'h3, 9'h151, D, 3'h1, D, 6'h0);
		dly <= 4'h0;
		run(A, 4'h3, 9'h158, 64'h7, 3'h1, 64'h0, 6'h0);
		run(A, 4'h3, 9'h168, 64'h8, 3'h1, '1, 6'h0);
		run(A + 64'h4, 4'h1, 9'h170, 64'h100, 3'h1, {PRE[63:32], 32'hffffffff}, 6'h0);
		run(A + 64'h4, 4'h1, 9'h158, 64'h3, 3'h1, {PRE[63:32], 32'h0}, 6'h0);
		$display("completion test done");
	endtask : testOk
	task automatic testFaults();
		msk = 3'h6;
		wr(OFS_IRQ_MASK, 32'h6);
		dly <= 4'h5;
		run(A + 64'h4, 4'h3, 9'h149, D, 3'h2, 64'h0, 6'h0);
		run(A + 64'h2, 4'h1, 9'h149, D, 3'h2, 64'h0, 6'h0);
		run(64'h0000800000000000, 4'h3, 9'h149, D, 3'h2, 64'h0, 6'h0);
		run(A, 4'h5, 9'h149, D, 3'h2, 64'h0, 6'h0);
		run(A, 4'h9, 9'h149, D, 3'h2, 64'h0, 6'h0);
		run(A, 4'h3, 9'h0c9, D, 3'h4, 64'h0, 6'h0);
		run(A, 4'h3, 9'h189, D, 3'h2, 64'h0, 6'h0);
		run(A, 4'h3, 9'h109, D, 3'h4, 64'h0, 6'h0);
		run(A, 4'h3, 9'h141, D, 3'h4, 64'h0, 6'h0);
		run(A, 4'h3, 9'h161, D, 3'h4, 64'h0, 6'h0);
		run(A, 4'h3, 9'h179, D, 3'h4, 64'h0, 6'h0);
		run(A + 64'h100, 4'h3, 9'h151, D, 3'h2, 64'h0, 6'h0);
		run(A, 4'h3, 9'h148, D, 3'h2, 64'h0, 6'h0);
		run(A, 4'h3, 9'h150, D, 3'h2, 64'h0, 6'h0);
		run(A, 4'h3, 9'h14d, D, 3'h1, PRE, 6'h1);
		run(A, 4'h1, 9'h14b, D, 3'h1, PRE, 6'h1);
		run(A + 64'h100, 4'h3, 9'h155, D, 3'h1, PRE, 6'h1);
		$display("fault test done");
	endtask : testFaults
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		{wbCyc, wbStb, wbWe} = 3'h0;
		wbAdr = 8'h0;
		wbSel = 4'hf;
		wbDatW = 32'h0;
		dly = 4'h0;
		msk = 3'h0;
		answer = '0;
		doneCount = 16'h0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		testReset();
		testOk();
		testFaults();
		endOfTest();
	end
endmodule : debug_enclave_read_bench
